// File: design/ocb_defs.svh
// Offsets, field positions, reset values and scale constants of the output config bank
`ifndef OCB_DEFS_SVH
`define OCB_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------------------------------------------
`define OCB_IDX_OUT5_BYPASS   9'h0A3
`define OCB_IDX_OUT5_RAMP     9'h0A4
`define OCB_IDX_OUT5_FRAC     9'h0A5
`define OCB_IDX_OUT6_BYPASS   9'h0A6
`define OCB_IDX_OUT6_RAMP     9'h0A7
`define OCB_IDX_OUT6_FRAC     9'h0A8
`define OCB_IDX_OUT7_BYPASS   9'h0A9
`define OCB_IDX_OUT7_RAMP     9'h0AA
`define OCB_IDX_OUT7_FRAC     9'h0AB
`define OCB_IDX_DIFF0         9'h0F0
`define OCB_IDX_DIFF1         9'h0F1
`define OCB_IDX_DIFF2         9'h0F4
`define OCB_IDX_DIFF3         9'h0F5
`define OCB_IDX_DUAL4         9'h140
`define OCB_IDX_DUAL5         9'h141
`define OCB_IDX_STATUS        9'h1F0

// ----------------------------------------------------------------------------
// Storage slots
// ----------------------------------------------------------------------------
`define OCB_NUM_SLOTS         16
`define OCB_SLOT_DIFF_BASE    4'h9
`define OCB_SLOT_DUAL_BASE    4'hD
`define OCB_SLOT_STATUS       4'hF
`define OCB_SLOTS_PER_DELAY   3

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define OCB_RST_BYPASS        8'h01
`define OCB_RST_RAMP          8'h00
`define OCB_RST_FRAC          8'h00
`define OCB_RST_DIFF_ON       8'h08
`define OCB_RST_DIFF_SAFE     8'h0A
`define OCB_RST_DUAL4         8'h42
`define OCB_RST_DUAL5         8'h43
`define OCB_RST_STATUS        8'h00
`define OCB_MASK_BYPASS       8'h01
`define OCB_MASK_RAMP         8'h3F
`define OCB_MASK_FRAC         8'h3F
`define OCB_MASK_DIFF         8'h1F
`define OCB_MASK_DUAL         8'hFF
`define OCB_MASK_STATUS       8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OCB_BYPASS_BIT        0
`define OCB_CAP_HI            5
`define OCB_CAP_LO            3
`define OCB_CUR_HI            2
`define OCB_CUR_LO            0
`define OCB_FRAC_HI           5
`define OCB_FRAC_LO           0
`define OCB_PECL_INV_BIT      4
`define OCB_SWING_HI          3
`define OCB_SWING_LO          2
`define OCB_PD_HI             1
`define OCB_PD_LO             0
`define OCB_POL_A_BIT         7
`define OCB_POL_B_BIT         6
`define OCB_POL_L_BIT         5
`define OCB_SEC_EN_BIT        4
`define OCB_LEVEL_BIT         3
`define OCB_LCUR_HI           2
`define OCB_LCUR_LO           1
`define OCB_DPD_BIT           0

// ----------------------------------------------------------------------------
// Analog scale figures
// ----------------------------------------------------------------------------
`define OCB_MAX_CAPS          4
`define OCB_RAMP_STEP_UA      200
`define OCB_FS_SCALE          840
`define OCB_FRAC_BITS         6
`define OCB_FRAC_MAX          6'h2F
`define OCB_SWING_MV_0        400
`define OCB_SWING_MV_1        600
`define OCB_SWING_MV_2        780
`define OCB_SWING_MV_3        960
`define OCB_LVDS_UA_0         1750
`define OCB_LVDS_UA_1         3500
`define OCB_LVDS_UA_2         5250
`define OCB_LVDS_UA_3         7000

`endif

// File: design/ocb_pkg.sv
// Types shared by the output config bank
package ocb_pkg;

  typedef enum logic [1:0] {
    OCB_PD_NORMAL,
    OCB_PD_PARTIAL_BARE,
    OCB_PD_PARTIAL_SAFE,
    OCB_PD_TOTAL
  } ocb_pecl_pd_t;

  typedef enum logic {
    OCB_LEVEL_LVDS,
    OCB_LEVEL_CMOS
  } ocb_level_t;

endpackage : ocb_pkg

// File: design/ocb_reg_mem.sv
// Register storage of the output config bank with registered read port
`timescale 1ns/1ns
module ocb_reg_mem #(
  parameter int              NUM     = 16,
  parameter int              W       = 8,
  parameter logic [NUM*W-1:0] RST_VAL = '0,
  parameter logic [NUM*W-1:0] WMASK   = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Write port
  input  wire logic             wr_en_i,
  input  wire logic [3:0]       wr_slot_i,
  input  wire logic [W-1:0]     wr_data_i,
  // Read port
  input  wire logic             rd_en_i,
  input  wire logic             rd_valid_i,
  input  wire logic [3:0]       rd_slot_i,
  input  wire logic [W-1:0]     ro_data_i,
  output logic      [W-1:0]     rd_data_o,
  // Parallel view of all slots
  output logic      [NUM*W-1:0] q_o
);

  logic [NUM*W-1:0] mem_reg;

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_reg <= RST_VAL;
    end else if (wr_en_i) begin
      mem_reg[wr_slot_i*W +: W] <= wr_data_i & WMASK[wr_slot_i*W +: W];
    end
  end

  // ----------------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      if (!rd_valid_i) begin
        rd_data_o <= '0;
      end else if (rd_slot_i == 4'(NUM - 1)) begin
        rd_data_o <= ro_data_i;
      end else begin
        rd_data_o <= mem_reg[rd_slot_i*W +: W];
      end
    end
  end

  assign q_o = mem_reg;

endmodule : ocb_reg_mem

// File: design/ocb_bank.sv
// Output driver configuration bank with classic Wishbone slave
`timescale 1ns/1ns
`include "ocb_defs.svh"

module ocb_bank #(
  parameter int ADR_W = 11
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Fine delay, index 0..2 = outputs 5..7
  output logic      [2:0]        dly_bypass_o,
  output logic      [8:0]        dly_caps_o,
  output logic      [32:0]       dly_ramp_ua_o,
  output logic      [35:0]       dly_full_scale_o,
  output logic      [35:0]       dly_amount_o,
  output logic      [2:0]        dly_frac_unsupported_o,
  // LVPECL outputs 0..3
  output logic      [3:0]        pecl_invert_o,
  output logic      [39:0]       pecl_swing_mv_o,
  output logic      [3:0]        pecl_on_o,
  output logic      [3:0]        pecl_ref_on_o,
  // Dual-mode outputs, index 0..1 = outputs 4..5
  output logic      [1:0]        dual_cmos_mode_o,
  output logic      [1:0]        dual_lvds_on_o,
  output logic      [1:0]        dual_lvds_invert_o,
  output logic      [25:0]       dual_lvds_ua_o,
  // CMOS outputs of channel 4
  output logic                   chan4_cmos_primary_on_o,
  output logic                   chan4_cmos_primary_inv_o,
  output logic                   chan4_cmos_secondary_on_o,
  output logic                   chan4_cmos_secondary_inv_o,
  // CMOS outputs of channel 5
  output logic                   chan5_cmos_primary_on_o,
  output logic                   chan5_cmos_primary_inv_o,
  output logic                   chan5_cmos_secondary_on_o,
  output logic                   chan5_cmos_secondary_inv_o
);

  localparam int NS = `OCB_NUM_SLOTS;
  localparam int DW = 8;

  localparam logic [NS*DW-1:0] RST_VAL = {
    `OCB_RST_STATUS,
    `OCB_RST_DUAL5,
    `OCB_RST_DUAL4,
    `OCB_RST_DIFF_SAFE,
    `OCB_RST_DIFF_ON,
    `OCB_RST_DIFF_SAFE,
    `OCB_RST_DIFF_ON,
    `OCB_RST_FRAC, `OCB_RST_RAMP, `OCB_RST_BYPASS,
    `OCB_RST_FRAC, `OCB_RST_RAMP, `OCB_RST_BYPASS,
    `OCB_RST_FRAC, `OCB_RST_RAMP, `OCB_RST_BYPASS
  };

  localparam logic [NS*DW-1:0] WMASK = {
    `OCB_MASK_STATUS,
    `OCB_MASK_DUAL,
    `OCB_MASK_DUAL,
    `OCB_MASK_DIFF,
    `OCB_MASK_DIFF,
    `OCB_MASK_DIFF,
    `OCB_MASK_DIFF,
    `OCB_MASK_FRAC, `OCB_MASK_RAMP, `OCB_MASK_BYPASS,
    `OCB_MASK_FRAC, `OCB_MASK_RAMP, `OCB_MASK_BYPASS,
    `OCB_MASK_FRAC, `OCB_MASK_RAMP, `OCB_MASK_BYPASS
  };

  // ----------------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------------
  function automatic logic [4:0] slot_of(input logic [8:0] idx);
    logic [4:0] r;
    r = 5'h00;
    unique case (idx)
      `OCB_IDX_OUT5_BYPASS: r = 5'h10;
      `OCB_IDX_OUT5_RAMP:   r = 5'h11;
      `OCB_IDX_OUT5_FRAC:   r = 5'h12;
      `OCB_IDX_OUT6_BYPASS: r = 5'h13;
      `OCB_IDX_OUT6_RAMP:   r = 5'h14;
      `OCB_IDX_OUT6_FRAC:   r = 5'h15;
      `OCB_IDX_OUT7_BYPASS: r = 5'h16;
      `OCB_IDX_OUT7_RAMP:   r = 5'h17;
      `OCB_IDX_OUT7_FRAC:   r = 5'h18;
      `OCB_IDX_DIFF0:       r = 5'h19;
      `OCB_IDX_DIFF1:       r = 5'h1A;
      `OCB_IDX_DIFF2:       r = 5'h1B;
      `OCB_IDX_DIFF3:       r = 5'h1C;
      `OCB_IDX_DUAL4:       r = 5'h1D;
      `OCB_IDX_DUAL5:       r = 5'h1E;
      `OCB_IDX_STATUS:      r = 5'h1F;
      default:              r = 5'h00;
    endcase
    return r;
  endfunction : slot_of

  function automatic logic [2:0] caps_of(input logic [2:0] code);
    return 3'(`OCB_MAX_CAPS - (int'(code[0]) + int'(code[1]) + int'(code[2])));
  endfunction : caps_of

  function automatic logic [10:0] ramp_ua_of(input logic [2:0] code);
    return 11'(`OCB_RAMP_STEP_UA * (int'(code) + 1));
  endfunction : ramp_ua_of

  function automatic logic [11:0] full_scale_of(input logic [2:0] caps,
                                                 input logic [2:0] code);
    return 12'((int'(caps) * `OCB_FS_SCALE) / (int'(code) + 1));
  endfunction : full_scale_of

  function automatic logic [12:0] swing_lut(input logic [1:0] code, input logic [12:0] v0,
                                             input logic [12:0] v1, input logic [12:0] v2,
                                             input logic [12:0] v3);
    logic [12:0] r;
    r = v0;
    unique case (code)
      2'h0: r = v0;
      2'h1: r = v1;
      2'h2: r = v2;
      2'h3: r = v3;
    endcase
    return r;
  endfunction : swing_lut

  // ----------------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------------
  logic             ack_reg;
  logic [4:0]       hit;
  logic             wr_en;
  logic             rd_en;
  logic [DW-1:0]    rd_data;
  logic [DW-1:0]    status_byte;
  logic [NS*DW-1:0] q;

  assign hit   = slot_of(adr_i[ADR_W-1:2]);
  // Read data captured on the taking edge, shown alongside ack
  assign rd_en = cyc_i && stb_i && !ack_reg;
  // Write lands on the edge where the master samples ack
  assign wr_en = cyc_i && stb_i && we_i && ack_reg
                 && sel_i[0]
                 && hit[4]
                 && (hit[3:0] != `OCB_SLOT_STATUS);

  // One-cycle answer, dropped even if stb stays high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i && stb_i && !ack_reg;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = {24'h000000, rd_data};

  // Status slot is read through the read-only data input
  ocb_reg_mem #(
    .NUM     (NS),
    .W       (DW),
    .RST_VAL (RST_VAL),
    .WMASK   (WMASK)
  ) u_mem (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_en_i    (wr_en),
    .wr_slot_i  (hit[3:0]),
    .wr_data_i  (dat_i[7:0]),
    .rd_en_i    (rd_en),
    .rd_valid_i (hit[4]),
    .rd_slot_i  (hit[3:0]),
    .ro_data_i  (status_byte),
    .rd_data_o  (rd_data),
    .q_o        (q)
  );

  // ----------------------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------------------
  // Dual output is live when powered in either level mode
  logic [1:0] dual_live;

  assign dual_live   = dual_lvds_on_o | {chan5_cmos_primary_on_o, chan4_cmos_primary_on_o};
  assign status_byte = {2'b00, dual_live, pecl_on_o};

  // ----------------------------------------------------------------------------
  // Fine delay decode
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_bypass_o           <= '1;
      dly_caps_o             <= {3{3'(`OCB_MAX_CAPS)}};
      dly_ramp_ua_o          <= {3{11'(`OCB_RAMP_STEP_UA)}};
      dly_full_scale_o       <= {3{12'(`OCB_MAX_CAPS * `OCB_FS_SCALE)}};
      dly_amount_o           <= '0;
      dly_frac_unsupported_o <= '0;
    end else begin
      for (int ch = 0; ch < 3; ch++) begin
        logic [7:0]  byp_b;
        logic [7:0]  ramp_b;
        logic [7:0]  frac_b;
        logic [2:0]  caps;
        logic [11:0] fs;
        logic [5:0]  frac;
        byp_b  = q[(ch*`OCB_SLOTS_PER_DELAY)*DW +: DW];
        ramp_b = q[(ch*`OCB_SLOTS_PER_DELAY+1)*DW +: DW];
        frac_b = q[(ch*`OCB_SLOTS_PER_DELAY+2)*DW +: DW];
        caps   = caps_of(ramp_b[`OCB_CAP_HI:`OCB_CAP_LO]);
        fs     = full_scale_of(caps, ramp_b[`OCB_CUR_HI:`OCB_CUR_LO]);
        frac   = frac_b[`OCB_FRAC_HI:`OCB_FRAC_LO];
        dly_bypass_o[ch]          <= byp_b[`OCB_BYPASS_BIT];
        dly_caps_o[ch*3 +: 3]     <= caps;
        dly_ramp_ua_o[ch*11 +: 11] <= ramp_ua_of(ramp_b[`OCB_CUR_HI:`OCB_CUR_LO]);
        dly_full_scale_o[ch*12 +: 12] <= fs;
        // Bypassed path or zero fraction adds nothing
        dly_amount_o[ch*12 +: 12] <= byp_b[`OCB_BYPASS_BIT] ? 12'h000 :
                                     12'((int'(fs) * int'(frac)) >> `OCB_FRAC_BITS);
        // Values above the supported ceiling are flagged, not altered
        dly_frac_unsupported_o[ch] <= frac > `OCB_FRAC_MAX;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // LVPECL decode
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pecl_invert_o   <= 4'h0;
      pecl_swing_mv_o <= {4{10'(`OCB_SWING_MV_2)}};
      pecl_on_o       <= 4'h5;
      pecl_ref_on_o   <= 4'hF;
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic [7:0]           b;
        ocb_pkg::ocb_pecl_pd_t pd;
        b  = q[(int'(`OCB_SLOT_DIFF_BASE) + i)*DW +: DW];
        pd = ocb_pkg::ocb_pecl_pd_t'(b[`OCB_PD_HI:`OCB_PD_LO]);
        pecl_invert_o[i]          <= b[`OCB_PECL_INV_BIT];
        pecl_swing_mv_o[i*10 +: 10] <= 10'(swing_lut(b[`OCB_SWING_HI:`OCB_SWING_LO],
                                        13'(`OCB_SWING_MV_0), 13'(`OCB_SWING_MV_1),
                                        13'(`OCB_SWING_MV_2), 13'(`OCB_SWING_MV_3)));
        pecl_on_o[i]     <= (pd == ocb_pkg::OCB_PD_NORMAL);
        // Bare partial code is left to software discipline
        pecl_ref_on_o[i] <= (pd != ocb_pkg::OCB_PD_TOTAL);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Dual-mode decode
  // ----------------------------------------------------------------------------
  logic [1:0] pri_on_next;
  logic [1:0] pri_inv_next;
  logic [1:0] sec_on_next;
  logic [1:0] sec_inv_next;
  logic [1:0] cmos_next;
  logic [1:0] lvds_on_next;
  logic [1:0] lvds_inv_next;
  logic [25:0] lvds_ua_next;

  // CMOS outputs stay off in LVDS mode; polarity is always decoded
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [7:0]           b;
      ocb_pkg::ocb_level_t  lvl;
      logic                 pwr;
      b   = q[(int'(`OCB_SLOT_DUAL_BASE) + i)*DW +: DW];
      lvl = ocb_pkg::ocb_level_t'(b[`OCB_LEVEL_BIT]);
      pwr = !b[`OCB_DPD_BIT];
      cmos_next[i]     = (lvl == ocb_pkg::OCB_LEVEL_CMOS);
      lvds_on_next[i]  = pwr && (lvl == ocb_pkg::OCB_LEVEL_LVDS);
      lvds_inv_next[i] = b[`OCB_POL_L_BIT];
      pri_on_next[i]   = pwr && cmos_next[i];
      pri_inv_next[i]  = b[`OCB_POL_A_BIT] ^ b[`OCB_POL_L_BIT];
      sec_inv_next[i]  = !(b[`OCB_POL_B_BIT] ^ b[`OCB_POL_L_BIT]);
      sec_on_next[i]   = pri_on_next[i] && b[`OCB_SEC_EN_BIT];
      lvds_ua_next[i*13 +: 13] = swing_lut(b[`OCB_LCUR_HI:`OCB_LCUR_LO],
                                  13'(`OCB_LVDS_UA_0), 13'(`OCB_LVDS_UA_1),
                                  13'(`OCB_LVDS_UA_2), 13'(`OCB_LVDS_UA_3));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dual_cmos_mode_o   <= 2'h0;
      dual_lvds_on_o     <= 2'h1;
      dual_lvds_invert_o <= 2'h0;
      dual_lvds_ua_o     <= {2{13'(`OCB_LVDS_UA_1)}};
    end else begin
      dual_cmos_mode_o   <= cmos_next;
      dual_lvds_on_o     <= lvds_on_next;
      dual_lvds_invert_o <= lvds_inv_next;
      dual_lvds_ua_o     <= lvds_ua_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan4_cmos_primary_on_o    <= 1'b0;
      chan4_cmos_primary_inv_o   <= 1'b0;
      chan4_cmos_secondary_on_o  <= 1'b0;
      chan4_cmos_secondary_inv_o <= 1'b0;
      chan5_cmos_primary_on_o    <= 1'b0;
      chan5_cmos_primary_inv_o   <= 1'b0;
      chan5_cmos_secondary_on_o  <= 1'b0;
      chan5_cmos_secondary_inv_o <= 1'b0;
    end else begin
      chan4_cmos_primary_on_o    <= pri_on_next[0];
      chan4_cmos_primary_inv_o   <= pri_inv_next[0];
      chan4_cmos_secondary_on_o  <= sec_on_next[0];
      chan4_cmos_secondary_inv_o <= sec_inv_next[0];
      chan5_cmos_primary_on_o    <= pri_on_next[1];
      chan5_cmos_primary_inv_o   <= pri_inv_next[1];
      chan5_cmos_secondary_on_o  <= sec_on_next[1];
      chan5_cmos_secondary_inv_o <= sec_inv_next[1];
    end
  end

endmodule : ocb_bank

// File: bench/ocb_bank_sva.sv
// Port-level checks of the output config bank
`timescale 1ns/1ns
module ocb_bank_sva (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // Decoded outputs
  input wire logic [2:0]  dly_bypass_o,
  input wire logic [8:0]  dly_caps_o,
  input wire logic [32:0] dly_ramp_ua_o,
  input wire logic [35:0] dly_full_scale_o,
  input wire logic [35:0] dly_amount_o,
  input wire logic [3:0]  pecl_on_o,
  input wire logic [3:0]  pecl_ref_on_o,
  input wire logic [1:0]  dual_cmos_mode_o,
  input wire logic [1:0]  dual_lvds_on_o,
  input wire logic        chan4_cmos_primary_on_o,
  input wire logic        chan4_cmos_secondary_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_answers_req: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i) && dat_o[31:8] == 24'h0)
    else $error("spurious ack or dirty upper read data");
  a_caps_in_range: assert property (dly_caps_o[2:0] inside {[3'h1:3'h4]} &&
    dly_caps_o[5:3] inside {[3'h1:3'h4]} && dly_caps_o[8:6] inside {[3'h1:3'h4]})
    else $error("capacitor count out of range");
  a_ramp_step: assert property (dly_ramp_ua_o[10:0] % 11'h0C8 == 11'h0 &&
    dly_ramp_ua_o[10:0] inside {[11'h0C8:11'h640]})
    else $error("ramp current not a 200 uA step");
  a_full_scale_ratio: assert property ($stable(dly_caps_o) && $stable(dly_ramp_ua_o) |->
    32'(dly_full_scale_o[11:0]) * 32'(dly_ramp_ua_o[10:0]) == 32'(dly_caps_o[2:0]) * 32'h29040)
    else $error("full scale does not follow caps over current");
  a_bypass_no_delay: assert property (dly_bypass_o[0] |-> dly_amount_o[11:0] == 12'h0)
    else $error("delay applied while bypassed");
  a_pecl_on_ref: assert property (pecl_on_o[0] |-> pecl_ref_on_o[0])
    else $error("output on with reference off");
  a_sec_needs_cmos: assert property (chan4_cmos_secondary_on_o |->
    chan4_cmos_primary_on_o && dual_cmos_mode_o[0])
    else $error("secondary output on outside CMOS mode");
  a_level_exclusive: assert property (!(dual_lvds_on_o[0] && dual_cmos_mode_o[0]))
    else $error("LVDS on while CMOS selected");
endmodule : ocb_bank_sva

bind ocb_bank ocb_bank_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o,
  .dly_bypass_o, .dly_caps_o, .dly_ramp_ua_o, .dly_full_scale_o, .dly_amount_o,
  .pecl_on_o, .pecl_ref_on_o, .dual_cmos_mode_o, .dual_lvds_on_o,
  .chan4_cmos_primary_on_o, .chan4_cmos_secondary_on_o);

// File: bench/tb_top.sv
// Self-checking bench for the output config bank
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module tb_top;
  // ----------------
  // Signals
  // ----------------
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [10:0] adr_i;
  logic [3:0]  sel_i, pecl_invert_o, pecl_on_o, pecl_ref_on_o, cm;
  logic [31:0] dat_i, dat_o;
  logic [2:0]  dly_bypass_o, dly_frac_unsupported_o, p;
  logic [8:0]  dly_caps_o, ix;
  logic [32:0] dly_ramp_ua_o;
  logic [35:0] dly_full_scale_o, dly_amount_o;
  logic [39:0] pecl_swing_mv_o;
  logic [1:0]  dual_cmos_mode_o, dual_lvds_on_o, dual_lvds_invert_o;
  logic [25:0] dual_lvds_ua_o;
  logic        chan4_cmos_primary_on_o, chan4_cmos_primary_inv_o;
  logic        chan4_cmos_secondary_on_o, chan4_cmos_secondary_inv_o;
  logic        chan5_cmos_primary_on_o, chan5_cmos_primary_inv_o;
  logic        chan5_cmos_secondary_on_o, chan5_cmos_secondary_inv_o;
  logic [7:0]  d;
  int          n_mismatch, cmp_count, cycles, n, m;
  logic [24:0] tab [15] = '{{9'h0A3, 16'h0101}, {9'h0A4, 16'h003F}, {9'h0A5, 16'h003F},
    {9'h0A6, 16'h0101}, {9'h0A7, 16'h003F}, {9'h0A8, 16'h003F}, {9'h0A9, 16'h0101},
    {9'h0AA, 16'h003F}, {9'h0AB, 16'h003F}, {9'h0F0, 16'h081F}, {9'h0F1, 16'h0A1F},
    {9'h0F4, 16'h081F}, {9'h0F5, 16'h0A1F}, {9'h140, 16'h42FF}, {9'h141, 16'h43FF}};
  logic [9:0]  sw [4] = '{10'h190, 10'h258, 10'h30C, 10'h3C0};
  logic [12:0] ua [4] = '{13'h06D6, 13'h0DAC, 13'h1482, 13'h1B58};
  logic [7:0]  fr [5] = '{8'h00, 8'h01, 8'h2F, 8'h30, 8'h3F};
  logic [8:0]  pidx [4] = '{9'h0F0, 9'h0F1, 9'h0F4, 9'h0F5};

  assign cm = ix[0] ? {chan5_cmos_primary_on_o, chan5_cmos_primary_inv_o,
                       chan5_cmos_secondary_on_o, chan5_cmos_secondary_inv_o}
                    : {chan4_cmos_primary_on_o, chan4_cmos_primary_inv_o,
                       chan4_cmos_secondary_on_o, chan4_cmos_secondary_inv_o};

  ocb_bank DUT (.*);

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------
  // Bus tasks
  // ----------------
  task automatic wb_cycle(input logic [8:0] a, input logic w, input logic [7:0] v,
                          input logic [3:0] s, output logic [7:0] r);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {a, 2'b00};
    sel_i <= s;
    dat_i <= {24'h0, v};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_cycle

  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    wb_cycle(a, 1'b1, v, 4'hF, d);
    repeat (2) @(posedge clk_i);
  endtask : wr

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    wb_cycle(a, 1'b0, 8'h00, 4'hF, d);
    `CHK(d, e)
  endtask : rd_chk

  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {4'h8, 47'h0};
    ix = 9'h000;
    repeat (3) @(posedge clk_i);
    `CHK(dly_bypass_o, 3'h7)
    `CHK(dly_caps_o, {3{3'h4}})
    `CHK(dly_ramp_ua_o, {3{11'h0C8}})
    `CHK(dly_full_scale_o, {3{12'hD20}})
    `CHK(dly_amount_o, 36'h0)
    `CHK({pecl_on_o, pecl_ref_on_o, pecl_invert_o}, 12'h5F0)
    `CHK(pecl_swing_mv_o, {4{10'h30C}})
    `CHK({dual_lvds_on_o, dual_cmos_mode_o}, 4'h4)
    `CHK(dual_lvds_ua_o, {2{13'h0DAC}})
    rst_i <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      rd_chk(tab[i][24:16], tab[i][15:8]);
      wr(tab[i][24:16], 8'hFF);
      rd_chk(tab[i][24:16], tab[i][7:0]);
      wr(tab[i][24:16], tab[i][15:8]);
    end
    for (int i = 0; i < 8; i++) begin
      m = 7 - i;
      n = 4 - $countones(3'(i));
      wr(9'h0A4, {2'b00, 3'(i), 3'(m)});
      `CHK(dly_caps_o[2:0], 3'(n))
      `CHK(dly_ramp_ua_o[10:0], 11'(32'h0C8 * (m + 1)))
      `CHK(dly_full_scale_o[11:0], 12'(n * 32'h348 / (m + 1)))
    end
    wr(9'h0A6, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(9'h0A8, fr[i]);
      `CHK(dly_amount_o[23:12], 12'((32'hD20 * fr[i]) >> 6))
      `CHK(dly_frac_unsupported_o[1], fr[i] > 8'h2F)
    end
    `CHK(dly_bypass_o[1], 1'b0)
    wr(9'h0A6, 8'h01);
    `CHK({dly_bypass_o[1], dly_amount_o[23:12]}, 13'h1000)
    for (int o = 0; o < 4; o++) begin
      for (int j = 0; j < 4; j++) begin
        wr(pidx[o], {3'b000, j[0], j[1:0], j[1:0]});
        `CHK(pecl_invert_o[o], j[0])
        `CHK(pecl_swing_mv_o[o*10 +: 10], sw[j])
        `CHK({pecl_on_o[o], pecl_ref_on_o[o]}, {j == 0, j != 3})
      end
    end
    for (int c = 0; c < 2; c++) begin
      ix = 9'h140 + 9'(c);
      for (int k = 0; k < 8; k++) begin
        p = 3'(k);
        wr(ix, {p, 5'b11000});
        `CHK(cm, {1'b1, p[2] ^ p[0], 1'b1, ~(p[1] ^ p[0])})
        wr(ix, {p, 2'b00, p[1:0], 1'b0});
        `CHK(dual_lvds_invert_o[c], p[0])
        `CHK(dual_lvds_ua_o[c*13 +: 13], ua[p[1:0]])
        `CHK({dual_lvds_on_o[c], dual_cmos_mode_o[c], cm[3], cm[1]}, 4'h8)
      end
      wr(ix, 8'h48);
      `CHK({cm[3], cm[1]}, 2'b10)
      rd_chk(9'h1F0, 8'(8'h10 << c));
      wr(ix, 8'h49);
      `CHK(cm[3], 1'b0)
      rd_chk(9'h1F0, 8'h00);
      wr(ix, 8'h43);
      `CHK(dual_lvds_on_o[c], 1'b0)
    end
    wr(9'h100, 8'h5A);
    rd_chk(9'h100, 8'h00);
    wb_cycle(9'h0A5, 1'b1, 8'h15, 4'hE, d);
    rd_chk(9'h0A5, 8'h00);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(9'h0F1, 8'h0A);
    `CHK(pecl_on_o, 4'h5)
    wr(9'h1F0, 8'hFF);
    rd_chk(9'h1F0, 8'h15);
    test_done();
  end
endmodule : tb_top
